// >>> oss_fault_detect.sv
`default_nettype none
module oss_fault_detect
    import oss_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     fault_pin,
    input  wire logic                     invert,
    input  wire logic [3:0]               mode,
    input  wire logic [3:0]               count_sel,
    input  wire logic [OSS_NUM_TICKS-1:0] tick,
    output logic                          req
);
    logic       level;
    logic       edge_mode;
    logic       sample_en;
    logic [4:0] need;
    logic [4:0] run_d;
    logic [4:0] run_q;
    logic       samp_q;
    logic       acc_q;
    logic       prev_q;
    logic       fire;

    assign level     = fault_pin ^ invert;                // RULE_07 RULE_10
    assign edge_mode = (mode == OSS_MODE_EDGE);           // RULE_01 RULE_08

    // Sample strobe per mode; forbidden codes never sample
    always_comb begin
        unique case (mode)
            OSS_MODE_DIV8:   sample_en = tick[OSS_TICK_D8];   // RULE_02
            OSS_MODE_DIV16:  sample_en = tick[OSS_TICK_D16];  // RULE_02
            OSS_MODE_DIV128: sample_en = tick[OSS_TICK_D128]; // RULE_02
            OSS_MODE_DIV1:   sample_en = tick[OSS_TICK_D1];   // RULE_03
            OSS_MODE_DIV2:   sample_en = tick[OSS_TICK_D2];   // RULE_03
            OSS_MODE_DIV4:   sample_en = tick[OSS_TICK_D4];   // RULE_03
            default:         sample_en = 1'b0;
        endcase
    end

    // Run length; forbidden codes fall back to 16
    always_comb begin
        if (count_sel == OSS_CNT_4) begin
            need = OSS_RUN_4;                             // RULE_06 RULE_09
        end else if (count_sel == OSS_CNT_8) begin
            need = OSS_RUN_8;
        end else if (count_sel != OSS_CNT_16 &&
                     count_sel <= OSS_CNT_MAX_CODE) begin
            need = {1'b0, count_sel} + OSS_RUN_OFFSET;
        end else begin
            need = OSS_RUN_16;
        end
    end

    // Consecutive equal samples, saturating at the needed length
    always_comb begin
        if (level != samp_q) begin
            run_d = 5'h01;
        end else if (run_q >= need) begin
            run_d = need;
        end else begin
            run_d = run_q + 5'h01;
        end
    end

    // Fire only on a settled level that differs from the last one taken
    assign fire = sample_en && (run_d >= need) && (level != acc_q); // RULE_05

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            run_q  <= 5'h00;
            samp_q <= 1'b1;
        end else if (sample_en) begin
            run_q  <= run_d;
            samp_q <= level;
        end
    end

    // Accepted level; idle high pin is the start point
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q  <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            prev_q <= level;
            if (edge_mode || fire) begin
                acc_q <= level;
            end
        end
    end

    // Request pulse, one cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req <= 1'b0;
        end else if (edge_mode) begin
            req <= (level != prev_q);                     // RULE_01
        end else begin
            req <= fire;                                  // RULE_05
        end
    end
endmodule
`default_nettype wire

// >>> oss_fault_src.sv
`default_nettype none
module oss_fault_src
    import oss_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic [OSS_NUM_IN-1:0] pin_cmd,
    input  wire logic [2:0]            flag_cmd,
    output var  logic [OSS_NUM_IN-1:0] fault_pin_n,
    output var  logic [2:0]            ext_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle high; they move only just after an edge
    initial fault_pin_n = '1;
    initial ext_flag = '0;
    always @(posedge clk_sys) begin
        fault_pin_n <= pin_cmd;
        ext_flag    <= flag_cmd;
    end
endmodule
`default_nettype wire

// >>> oss_pkg.sv
// Operation
// RULE_01: Fault12 mode 0000 accepts either pin edge.
// RULE_02: Fault12 modes 1-3 sample at PCLK/8,16,128.
// RULE_03: Fault12 modes 4-6 sample at PCLK,/2,/4.
// RULE_04: Software writes only listed mode, count codes.
// RULE_05: Sampled request needs equal consecutive level run.
// RULE_06: Count code: 0=16, 1=4, 2=8, 3-9=9-15.
// RULE_07: Fault12 invert bit flips sensed pin polarity.
// RULE_08: Fault9 mode field mirrors fault12 encodings.
// RULE_09: Fault9 count field mirrors fault12 run encoding.
// RULE_10: Fault9 invert bit flips sensed pin polarity.
// RULE_11: Channel7 stop enable stops outputs when one.
// RULE_12: Select bit adds comparator flag to stop.
// RULE_13: Select bits add fault0, fault4, fault8 flags.
// RULE_14: Select bits add fault10, fault11 flags.
// RULE_15: Select one includes flag, zero excludes it.
// RULE_16: Faults 8,10,11 share the same detection encodings.
// RULE_17: Accepted request sets flag until software clears.
// RULE_18: Channel7 stays stopped while selected flag set.
`default_nettype none
package oss_pkg;
    // Register port geometry
    localparam int OSS_ADDR_W = 8;
    localparam int OSS_DATA_W = 16;
    // Detected inputs: 0=fault12, 1=fault9, 2=fault8, 3=fault10, 4=fault11
    localparam int OSS_NUM_IN = 5;
    localparam int OSS_IN_F12 = 0;
    localparam int OSS_IN_F9  = 1;
    localparam int OSS_IN_F8  = 2;
    localparam int OSS_IN_F10 = 3;
    localparam int OSS_IN_F11 = 4;
    // Register byte offsets
    localparam logic [7:0] OSS_OFS_CTRL_BASE = 8'h00;
    localparam logic [7:0] OSS_OFS_STRIDE    = 8'h04;
    localparam logic [7:0] OSS_OFS_SW_STOP   = 8'h14;
    localparam logic [7:0] OSS_OFS_COND_SEL  = 8'h18;
    localparam logic [7:0] OSS_OFS_FLAGS     = 8'h1C;
    localparam logic [7:0] OSS_OFS_IRQ_MASK  = 8'h20;
    // Control register fields
    localparam int OSS_MODE_LSB = 0;
    localparam int OSS_CNT_LSB  = 4;
    localparam int OSS_INV_BIT  = 8;
    localparam int OSS_CTRL_W   = 9;
    localparam logic [OSS_CTRL_W-1:0] OSS_CTRL_RST = 9'h000;
    // Mode codes
    localparam logic [3:0] OSS_MODE_EDGE   = 4'h0;
    localparam logic [3:0] OSS_MODE_DIV8   = 4'h1;
    localparam logic [3:0] OSS_MODE_DIV16  = 4'h2;
    localparam logic [3:0] OSS_MODE_DIV128 = 4'h3;
    localparam logic [3:0] OSS_MODE_DIV1   = 4'h4;
    localparam logic [3:0] OSS_MODE_DIV2   = 4'h5;
    localparam logic [3:0] OSS_MODE_DIV4   = 4'h6;
    // Sample count codes and run lengths
    localparam logic [3:0] OSS_CNT_16       = 4'h0;
    localparam logic [3:0] OSS_CNT_4        = 4'h1;
    localparam logic [3:0] OSS_CNT_8        = 4'h2;
    localparam logic [3:0] OSS_CNT_MAX_CODE = 4'h9;
    localparam logic [4:0] OSS_RUN_16       = 5'h10;
    localparam logic [4:0] OSS_RUN_4        = 5'h04;
    localparam logic [4:0] OSS_RUN_8        = 5'h08;
    localparam logic [4:0] OSS_RUN_OFFSET   = 5'h06;
    // Sample ticks: PCLK/1, /2, /4, /8, /16, /128
    localparam int OSS_NUM_TICKS = 6;
    localparam int OSS_TICK_D1   = 0;
    localparam int OSS_TICK_D2   = 1;
    localparam int OSS_TICK_D4   = 2;
    localparam int OSS_TICK_D8   = 3;
    localparam int OSS_TICK_D16  = 4;
    localparam int OSS_TICK_D128 = 5;
    localparam int OSS_PRESC_W   = 7;
    // Stop condition select bits
    localparam int OSS_SEL_W   = 8;
    localparam int OSS_SEL_CMP = 0;
    localparam int OSS_SEL_F0  = 1;
    localparam int OSS_SEL_F4  = 2;
    localparam int OSS_SEL_F8  = 3;
    localparam int OSS_SEL_F10 = 4;
    localparam int OSS_SEL_F11 = 5;
    localparam int OSS_SEL_F12 = 6;
    localparam int OSS_SEL_F9  = 7;
    localparam logic [OSS_SEL_W-1:0] OSS_SEL_RST = 8'h00;
    localparam int OSS_SW_STOP_BIT = 0;
endpackage
`default_nettype wire

// >>> oss_prescaler.sv
`default_nettype none
module oss_prescaler
    import oss_pkg::*;
#(
    parameter int PRESC_W = OSS_PRESC_W
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    output logic      [OSS_NUM_TICKS-1:0] tick
);
    logic [PRESC_W-1:0] cnt_q;

    // Free running divider shared by all inputs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // One-cycle strobe when the low bits wrap
    genvar k;
    generate
        for (k = 0; k < OSS_NUM_TICKS; k++) begin : g_tick
            localparam int SH = (k == OSS_TICK_D128) ? 7 : k;
            if (SH == 0) begin : g_full
                assign tick[k] = 1'b1;
            end else begin : g_div
                assign tick[k] = &cnt_q[SH-1:0];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> oss_sva.sv
`default_nettype none
module oss_sva
    import oss_pkg::*;
#(
    parameter int PRESC_W = OSS_PRESC_W
) (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic [OSS_ADDR_W-1:0] reg_addr,
    input wire logic [OSS_DATA_W-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [OSS_DATA_W-1:0] reg_rdata_q,
    input wire logic                  fault12_pin,
    input wire logic                  fault9_pin,
    input wire logic                  fault8_pin,
    input wire logic                  fault10_pin,
    input wire logic                  fault11_pin,
    input wire logic                  comparator_detect_flag,
    input wire logic                  fault0_detect_flag,
    input wire logic                  fault4_detect_flag,
    input wire logic                  ch7_stop_q,
    input wire logic                  irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [OSS_CTRL_W-1:0] ctl12_q;
    logic [OSS_SEL_W-1:0]  sel_q;
    logic                  sw_q;
    logic [4:0]            msk_q;

    // Shadow of the registers the properties depend on
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl12_q <= '0;
            sel_q   <= '0;
            sw_q    <= 1'b0;
            msk_q   <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                OSS_OFS_CTRL_BASE: ctl12_q <= reg_wdata[OSS_CTRL_W-1:0];
                OSS_OFS_COND_SEL:  sel_q   <= reg_wdata[OSS_SEL_W-1:0];
                OSS_OFS_SW_STOP:   sw_q    <= reg_wdata[OSS_SW_STOP_BIT];
                OSS_OFS_IRQ_MASK:  msk_q   <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Reset must clear every output even while still held
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> reg_rdata_q == '0 && !ch7_stop_q && !irq_q)
        else $error("outputs not cleared by reset");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == '0)
        else $error("read data without a read strobe");
    a_sw_stop: assert property (sw_q [*3] |-> ch7_stop_q)
        else $error("software stop did not stop outputs");
    a_none_run: assert property (
        (sel_q == '0 && !sw_q) [*3] |-> !ch7_stop_q)
        else $error("outputs stopped with nothing selected");
    a_cmp_stop: assert property (
        (sel_q[OSS_SEL_CMP] && comparator_detect_flag) [*3] |-> ch7_stop_q)
        else $error("comparator flag did not stop outputs");
    a_ext_stop: assert property (
        ((sel_q[OSS_SEL_F0] && fault0_detect_flag)
        || (sel_q[OSS_SEL_F4] && fault4_detect_flag)) [*3] |-> ch7_stop_q)
        else $error("fault flag did not stop outputs");
    // Sticky flags keep the stop until software writes
    a_stop_holds: assert property (
        ch7_stop_q && sel_q[2:0] == '0 && !reg_wr && !$past(reg_wr)
        |=> ch7_stop_q)
        else $error("stop released without a write");
    a_edge_stop: assert property (
        ctl12_q[3:0] == OSS_MODE_EDGE && sel_q[OSS_SEL_F12] && !reg_wr
        && $changed(fault12_pin) |-> ##[1:4] ch7_stop_q)
        else $error("pin edge did not stop outputs");
    a_run_exact: assert property (
        (ctl12_q == 9'h014 && sel_q == 8'h40 && !sw_q && !ch7_stop_q
        && $fell(fault12_pin)) ##1 (!fault12_pin) [*3]
        |-> ##2 !ch7_stop_q ##1 ch7_stop_q)
        else $error("run of four samples mistimed");
    a_irq_masked: assert property ((msk_q == '0) [*2] |-> !irq_q)
        else $error("interrupt with every source masked");
endmodule

bind oss_top oss_sva #(.PRESC_W(PRESC_W)) u_sva (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .fault12_pin, .fault9_pin, .fault8_pin, .fault10_pin,
    .fault11_pin, .comparator_detect_flag, .fault0_detect_flag,
    .fault4_detect_flag, .ch7_stop_q, .irq_q
);
`default_nettype wire

// >>> oss_top.sv
`default_nettype none
module oss_top
    import oss_pkg::*;
#(
    parameter int PRESC_W = OSS_PRESC_W
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [OSS_ADDR_W-1:0] reg_addr,
    input  wire logic [OSS_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [OSS_DATA_W-1:0] reg_rdata_q,
    input  wire logic                  fault12_pin,
    input  wire logic                  fault9_pin,
    input  wire logic                  fault8_pin,
    input  wire logic                  fault10_pin,
    input  wire logic                  fault11_pin,
    input  wire logic                  comparator_detect_flag,
    input  wire logic                  fault0_detect_flag,
    input  wire logic                  fault4_detect_flag,
    output var  logic                  ch7_stop_q,
    output var  logic                  irq_q
);
    // Per-input pins and control storage
    logic [OSS_NUM_IN-1:0]    pin_vec;
    logic [OSS_CTRL_W-1:0]    ctrl_q [OSS_NUM_IN];
    logic [OSS_NUM_IN-1:0]    ctrl_wr;
    logic [OSS_NUM_IN-1:0]    ctrl_hit;
    logic [OSS_NUM_IN-1:0]    req;
    logic [OSS_NUM_TICKS-1:0] tick;

    // Flags, mask and stop controls
    logic [OSS_NUM_IN-1:0]    flag_q;
    logic [OSS_NUM_IN-1:0]    flag_d;
    logic [OSS_NUM_IN-1:0]    flag_clr;
    logic [OSS_NUM_IN-1:0]    mask_q;
    logic [OSS_SEL_W-1:0]     sel_q;
    logic [OSS_SEL_W-1:0]     cond_vec;
    logic                     sw_stop_q;
    logic                     stop_d;

    // Register decode
    logic                     hit_sw_stop;
    logic                     hit_cond_sel;
    logic                     hit_flags;
    logic                     hit_mask;
    logic [OSS_DATA_W-1:0]    rd_mux;
    logic [OSS_DATA_W-1:0]    ctrl_rd;

    // Pin order follows the input index constants
    assign pin_vec[OSS_IN_F12] = fault12_pin;
    assign pin_vec[OSS_IN_F9]  = fault9_pin;
    assign pin_vec[OSS_IN_F8]  = fault8_pin;
    assign pin_vec[OSS_IN_F10] = fault10_pin;
    assign pin_vec[OSS_IN_F11] = fault11_pin;

    // Fixed register decodes
    assign hit_sw_stop  = (reg_addr == OSS_OFS_SW_STOP);
    assign hit_cond_sel = (reg_addr == OSS_OFS_COND_SEL);
    assign hit_flags    = (reg_addr == OSS_OFS_FLAGS);
    assign hit_mask     = (reg_addr == OSS_OFS_IRQ_MASK);

    // Shared sample tick source, so every input sees the same phase
    oss_prescaler #(
        .PRESC_W (PRESC_W)
    ) u_presc (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    // One control register and one detector per fault input
    genvar i;
    generate
        for (i = 0; i < OSS_NUM_IN; i++) begin : g_in
            localparam logic [7:0] OFS =
                8'(OSS_OFS_CTRL_BASE + 8'(i) * OSS_OFS_STRIDE);

            assign ctrl_hit[i] = (reg_addr == OFS);
            assign ctrl_wr[i]  = reg_wr && ctrl_hit[i];

            // Mode, count and invert; upper bits are not stored
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    ctrl_q[i] <= OSS_CTRL_RST;
                end else if (ctrl_wr[i]) begin
                    ctrl_q[i] <= reg_wdata[OSS_CTRL_W-1:0]; // RULE_08
                end
            end

            // Same engine for 12, 9, 8, 10 and 11
            oss_fault_detect u_det (                  // RULE_16
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .fault_pin (pin_vec[i]),
                .invert    (ctrl_q[i][OSS_INV_BIT]),
                .mode      (ctrl_q[i][OSS_MODE_LSB+:4]),
                .count_sel (ctrl_q[i][OSS_CNT_LSB+:4]),
                .tick      (tick),
                .req       (req[i])
            );
        end
    endgenerate

    // Write-one-to-clear mask from the flag register write
    assign flag_clr = (reg_wr && hit_flags) ?
                      reg_wdata[OSS_NUM_IN-1:0] : '0;

    // A request in the clearing cycle wins over the clear
    assign flag_d = (flag_q & ~flag_clr) | req;           // RULE_17

    // Sticky detection flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;                             // RULE_17
        end
    end

    // Interrupt mask, same layout as the flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_q <= '0;
        end else if (reg_wr && hit_mask) begin
            mask_q <= reg_wdata[OSS_NUM_IN-1:0];
        end
    end

    // Software stop request for channel 7
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sw_stop_q <= 1'b0;
        end else if (reg_wr && hit_sw_stop) begin
            sw_stop_q <= reg_wdata[OSS_SW_STOP_BIT];      // RULE_11
        end
    end

    // Stop condition select bits
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sel_q <= OSS_SEL_RST;
        end else if (reg_wr && hit_cond_sel) begin
            sel_q <= reg_wdata[OSS_SEL_W-1:0];            // RULE_12 RULE_13
        end
    end

    // Candidate conditions lined up with the select bits
    assign cond_vec[OSS_SEL_CMP] = comparator_detect_flag; // RULE_12
    assign cond_vec[OSS_SEL_F0]  = fault0_detect_flag;     // RULE_13
    assign cond_vec[OSS_SEL_F4]  = fault4_detect_flag;     // RULE_13
    assign cond_vec[OSS_SEL_F8]  = flag_q[OSS_IN_F8];      // RULE_13
    assign cond_vec[OSS_SEL_F10] = flag_q[OSS_IN_F10];     // RULE_14
    assign cond_vec[OSS_SEL_F11] = flag_q[OSS_IN_F11];     // RULE_14
    assign cond_vec[OSS_SEL_F12] = flag_q[OSS_IN_F12];
    assign cond_vec[OSS_SEL_F9]  = flag_q[OSS_IN_F9];

    // Stop while software asks or any selected flag stands
    assign stop_d = sw_stop_q | (|(sel_q & cond_vec));   // RULE_15 RULE_18

    // Registered stop output; held as long as the cause holds
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ch7_stop_q <= 1'b0;
        end else begin
            ch7_stop_q <= stop_d;                         // RULE_11 RULE_18
        end
    end

    // Level interrupt from unmasked sticky flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flag_q & mask_q);
        end
    end

    // Control register read-back; one hit at most
    always_comb begin
        ctrl_rd = '0;
        for (int k = 0; k < OSS_NUM_IN; k++) begin
            if (ctrl_hit[k]) begin
                ctrl_rd = {{(OSS_DATA_W-OSS_CTRL_W){1'b0}}, ctrl_q[k]};
            end
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        if (|ctrl_hit) begin
            rd_mux = ctrl_rd;
        end else if (hit_sw_stop) begin
            rd_mux = {{(OSS_DATA_W-1){1'b0}}, sw_stop_q};
        end else if (hit_cond_sel) begin
            rd_mux = {{(OSS_DATA_W-OSS_SEL_W){1'b0}}, sel_q};
        end else if (hit_flags) begin
            rd_mux = {{(OSS_DATA_W-OSS_NUM_IN){1'b0}}, flag_q};
        end else if (hit_mask) begin
            rd_mux = {{(OSS_DATA_W-OSS_NUM_IN){1'b0}}, mask_q};
        end else begin
            rd_mux = '0;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= '0;
        end
    end
endmodule
`default_nettype wire

// >>> tb_oss_top.sv
`default_nettype none
`define CHK(nm, exp, got) \
    checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("Error %s expected %h seen %h", nm, exp, got); \
    end
module tb_oss_top
    import oss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] pin;
        logic [3:0] mode;
        logic [3:0] cnt;
        logic [7:0] per;
        logic [4:0] run;
    } oss_row_t;
    // Input, mode, count code, sample period, run length it needs
    localparam oss_row_t ROWS [19] = '{
        '{3'h0,4'h4,4'h0,8'h01,5'h10}, '{3'h0,4'h4,4'h1,8'h01,5'h04},
        '{3'h0,4'h4,4'h2,8'h01,5'h08}, '{3'h0,4'h4,4'h3,8'h01,5'h09},
        '{3'h0,4'h4,4'h4,8'h01,5'h0A}, '{3'h0,4'h4,4'h5,8'h01,5'h0B},
        '{3'h0,4'h4,4'h6,8'h01,5'h0C}, '{3'h0,4'h4,4'h7,8'h01,5'h0D},
        '{3'h0,4'h4,4'h8,8'h01,5'h0E}, '{3'h0,4'h4,4'h9,8'h01,5'h0F},
        '{3'h0,4'h1,4'h1,8'h08,5'h04}, '{3'h0,4'h2,4'h1,8'h10,5'h04},
        '{3'h0,4'h3,4'h1,8'h80,5'h04}, '{3'h0,4'h5,4'h1,8'h02,5'h04},
        '{3'h0,4'h6,4'h1,8'h04,5'h04}, '{3'h1,4'h4,4'h3,8'h01,5'h09},
        '{3'h1,4'h2,4'h8,8'h10,5'h0E}, '{3'h1,4'h4,4'h0,8'h01,5'h10},
        '{3'h4,4'h6,4'h2,8'h04,5'h08}};
    localparam int SEL_OF [OSS_NUM_IN] = '{OSS_SEL_F12, OSS_SEL_F9,
        OSS_SEL_F8, OSS_SEL_F10, OSS_SEL_F11};
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    logic [OSS_ADDR_W-1:0] reg_addr = '0;
    logic [OSS_DATA_W-1:0] reg_wdata = '0;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [OSS_DATA_W-1:0] reg_rdata_q;
    logic [OSS_NUM_IN-1:0] pin_cmd = '1;
    logic [2:0]            flag_cmd = '0;
    logic [OSS_NUM_IN-1:0] pin_n;
    logic [2:0]            ext_flag;
    logic                  ch7_stop_q;
    logic                  irq_q;
    logic [OSS_DATA_W-1:0] rdv;
    oss_row_t              r;
    int                    mismatches = 0;
    int                    checked = 0;
    int                    cycles = 0;

    always #5 clk_sys = ~clk_sys;

    oss_fault_src u_src (.clk_sys(clk_sys), .pin_cmd(pin_cmd),
        .flag_cmd(flag_cmd), .fault_pin_n(pin_n), .ext_flag(ext_flag));
    oss_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .fault12_pin(pin_n[OSS_IN_F12]),
        .fault9_pin(pin_n[OSS_IN_F9]), .fault8_pin(pin_n[OSS_IN_F8]),
        .fault10_pin(pin_n[OSS_IN_F10]), .fault11_pin(pin_n[OSS_IN_F11]),
        .comparator_detect_flag(ext_flag[0]),
        .fault0_detect_flag(ext_flag[1]), .fault4_detect_flag(ext_flag[2]),
        .ch7_stop_q(ch7_stop_q), .irq_q(irq_q));

    // Bus cycles start one edge after the call, so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 rdv = reg_rdata_q;
    endtask
    // Ends off the edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input int i, input int len);
        @(posedge clk_sys);
        pin_cmd[i] <= 1'b0;
        repeat (len) @(posedge clk_sys);
        pin_cmd[i] <= 1'b1;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A run well past the expected length counts as a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // One short run below the need, one that just meets it
        foreach (ROWS[k]) begin
            r = ROWS[k];
            wr(8'(OSS_OFS_STRIDE * r.pin), {8'h00, r.cnt, r.mode});
            wr(OSS_OFS_COND_SEL, 16'(1 << SEL_OF[r.pin]));
            pulse(r.pin, (r.run - 1) * r.per);
            cyc((r.run + 1) * r.per + 4);
            rd(OSS_OFS_FLAGS);
            `CHK("short run", 16'h0000, rdv)
            pulse(r.pin, (r.run + 1) * r.per - 1);
            cyc(3);
            rd(OSS_OFS_FLAGS);
            `CHK("full run", 16'(1 << r.pin), rdv)
            `CHK("run stop", 1'b1, ch7_stop_q)
            cyc((r.run + 1) * r.per + 4);
            wr(OSS_OFS_FLAGS, 16'h001F);
        end
        // Falling then rising edge on each input, interrupt masked first
        for (int i = 0; i < OSS_NUM_IN; i++) begin
            wr(8'(OSS_OFS_STRIDE * i), {8'h00, OSS_CNT_4, OSS_MODE_EDGE});
            wr(OSS_OFS_COND_SEL, 16'(1 << SEL_OF[i]));
            for (int e = 0; e < 2; e++) begin
                @(posedge clk_sys);
                pin_cmd[i] <= e[0];
                cyc(6);
                `CHK("edge stop", 1'b1, ch7_stop_q)
                rd(OSS_OFS_FLAGS);
                `CHK("edge flag", 16'(1 << i), rdv)
                `CHK("masked irq", 1'b0, irq_q)
                wr(OSS_OFS_IRQ_MASK, 16'(1 << i));
                cyc(1);
                `CHK("irq", 1'b1, irq_q)
                wr(OSS_OFS_FLAGS, 16'(1 << i));
                cyc(1);
                `CHK("cleared stop", 1'b0, ch7_stop_q)
                `CHK("cleared irq", 1'b0, irq_q)
                wr(OSS_OFS_IRQ_MASK, 16'h0000);
            end
        end
        // Inverting an idle pin looks like an edge
        for (int i = 0; i < 2; i++) begin
            wr(8'(OSS_OFS_STRIDE * i), 16'h0100);
            cyc(6);
            rd(OSS_OFS_FLAGS);
            `CHK("invert flag", 16'(1 << i), rdv)
            wr(OSS_OFS_FLAGS, 16'h001F);
        end
        // External flags are levels and only count when selected
        wr(OSS_OFS_COND_SEL, 16'h0000);
        for (int j = 0; j < 3; j++) begin
            @(posedge clk_sys);
            flag_cmd[j] <= 1'b1;
            cyc(4);
            `CHK("unselected", 1'b0, ch7_stop_q)
            wr(OSS_OFS_COND_SEL, 16'(1 << j));
            cyc(2);
            `CHK("selected", 1'b1, ch7_stop_q)
            @(posedge clk_sys);
            flag_cmd[j] <= 1'b0;
            cyc(4);
            `CHK("released", 1'b0, ch7_stop_q)
        end
        wr(OSS_OFS_SW_STOP, 16'h0001);
        cyc(2);
        `CHK("sw stop", 1'b1, ch7_stop_q)
        wr(OSS_OFS_SW_STOP, 16'h0000);
        cyc(2);
        `CHK("sw run", 1'b0, ch7_stop_q)
        // Upper bits read zero; a reset mid-run clears all
        wr(OSS_OFS_COND_SEL, 16'hFFA5);
        rd(OSS_OFS_COND_SEL);
        `CHK("select", 16'h00A5, rdv)
        wr(8'h04, 16'hFE96);
        rd(8'h04);
        `CHK("ctrl", 16'h0096, rdv)
        wr(8'h24, 16'hFFFF);
        wr(OSS_OFS_SW_STOP, 16'h0001);
        wr(OSS_OFS_IRQ_MASK, 16'h001F);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        cyc(2);
        `CHK("reset stop", 1'b0, ch7_stop_q)
        @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            rd(8'(4 * a));
            `CHK("reset value", 16'h0000, rdv)
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
